// File: src/cfo_fifo.sv
// What this block does
// - Optional clear resynchronised to read side.
// - Related clocks choose fewer crossing stages.
// - Optional extra register on read data.
// - Dual mode: registered normal, unregistered show-ahead.
// - Near-full when count at least threshold.
// - Near-empty when count below threshold.
// - Full-cycle option (single mode only): full takes read+write, stays full.
// - Ignore writes when full, reads when empty.
// - Sync depth setting reduced by two.
// - Show-ahead selects output data presentation.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module cfo_fifo import cfo_pkg::*; (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aclr,
	// Register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Write side
	input wire logic wr_req,
	input wire logic [DATA_W-1:0] wr_data,
	output logic full,
	output logic near_full,
	output logic [PTR_W-1:0] wr_count,
	// Read side
	input wire logic rd_req,
	output logic [DATA_W-1:0] rd_data,
	output logic empty,
	output logic near_empty,
	output logic [PTR_W-1:0] rd_count,
	// Interrupt
	output logic irq
);

	// ==========================================================
	// Register file state
	cfo_ctrl_t ctrl, next_ctrl;
	cfo_thresh_t thresh, next_thresh;
	logic [IRQ_W-1:0] irq_stat, next_irq_stat;
	logic [IRQ_W-1:0] irq_mask, next_irq_mask;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic wr_take, rd_take;
	logic [31:0] wmask, status_word, rd_word;

	// ==========================================================
	// Buffer state
	logic [DATA_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr, next_wr_ptr, wr_gray, next_wr_gray;
	logic [PTR_W-1:0] rd_ptr, next_rd_ptr, rd_gray, next_rd_gray;
	logic [PTR_W-1:0] wr_gray_s, rd_gray_s;
	logic [DATA_W-1:0] q0, next_q0, q1;
	logic full_d, empty_d;
	logic wr_ok, rd_ok, fc_eff, out_reg_eff, clr_s;
	logic rd_aclr, rd_sclr;
	logic [2:0] stages;
	logic [IRQ_W-1:0] events;

	// ==========================================================
	// Crossing depth and clear steering
	always_comb begin
		if (ctrl.sync_depth > SYNC_BIAS) begin
			stages = ctrl.sync_depth - SYNC_BIAS;
		end else begin
			stages = 3'h1;
		end
		if (stages > 3'(SYNC_MAX)) begin
			stages = 3'(SYNC_MAX);
		end
		if (ctrl.related_clk) begin
			stages = 3'h1;
		end
	end

	cfo_sync #(.W(1)) u_clr_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(1'b0),
		.depth(CLR_STAGES),
		.d(aclr),
		.q(clr_s)
	);

	// With resync on, the read side only sees the clear after the chain, so a
	// read request can still land half way through the clear.
	assign rd_aclr = aclr & ~ctrl.clr_sync;
	assign rd_sclr = ~aresetn | (ctrl.clr_sync & clr_s);

	// The chains are only exercised in dual mode; in single mode counts come
	// straight from the local pointers.
	cfo_sync #(.W(PTR_W)) u_wr2rd (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(aclr),
		.depth(stages),
		.d(wr_gray),
		.q(wr_gray_s)
	);

	cfo_sync #(.W(PTR_W)) u_rd2wr (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(rd_aclr),
		.depth(stages),
		.d(rd_gray),
		.q(rd_gray_s)
	);

	// ==========================================================
	// Flags, acceptance and pointers
	always_comb begin
		if (ctrl.dual_mode) begin
			wr_count = wr_ptr - gray2bin(rd_gray_s);
			rd_count = gray2bin(wr_gray_s) - rd_ptr;
		end else begin
			wr_count = wr_ptr - rd_ptr;
			rd_count = wr_ptr - rd_ptr;
		end
		full = (wr_count == DEPTH);
		empty = (rd_count == '0);
		near_full = (wr_count >= thresh.near_full);
		near_empty = (rd_count < thresh.near_empty);
		fc_eff = ctrl.full_cycle & ctrl.ovf_prot & ~ctrl.dual_mode;
		rd_ok = rd_req & ~(empty & ctrl.unf_prot);
		wr_ok = wr_req & (~(full & ctrl.ovf_prot) | (fc_eff & rd_ok));
		next_wr_ptr = wr_ok ? wr_ptr + 5'h01 : wr_ptr;
		next_rd_ptr = rd_ok ? rd_ptr + 5'h01 : rd_ptr;
		next_wr_gray = bin2gray(next_wr_ptr);
		next_rd_gray = bin2gray(next_rd_ptr);
		if (ctrl.dual_mode) begin
			out_reg_eff = ~ctrl.show_ahead;
		end else begin
			out_reg_eff = ctrl.out_reg;
		end
		if (ctrl.show_ahead) begin
			if (wr_ok && wr_ptr[IDX_W-1:0] == next_rd_ptr[IDX_W-1:0]) begin
				next_q0 = wr_data;
			end else begin
				next_q0 = mem[next_rd_ptr[IDX_W-1:0]];
			end
		end else if (rd_ok) begin
			next_q0 = mem[rd_ptr[IDX_W-1:0]];
		end else begin
			next_q0 = q0;
		end
		rd_data = out_reg_eff ? q1 : q0;
	end

	always_ff @(posedge aclk) begin
		if (wr_ok) begin
			mem[wr_ptr[IDX_W-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge aclk or posedge aclr) begin
		if (aclr) begin
			wr_ptr <= '0;
			wr_gray <= '0;
		end else if (!aresetn) begin
			wr_ptr <= '0;
			wr_gray <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			wr_gray <= next_wr_gray;
		end
	end

	always_ff @(posedge aclk or posedge rd_aclr) begin
		if (rd_aclr) begin
			rd_ptr <= '0;
			rd_gray <= '0;
			q0 <= '0;
			q1 <= '0;
		end else if (rd_sclr) begin
			rd_ptr <= '0;
			rd_gray <= '0;
			q0 <= '0;
			q1 <= '0;
		end else begin
			rd_ptr <= next_rd_ptr;
			rd_gray <= next_rd_gray;
			q0 <= next_q0;
			q1 <= q0;
		end
	end

	// ==========================================================
	// Register bus slave
	always_comb begin
		// Address and data are taken together, and only once the previous
		// response has gone, so at most one write is ever outstanding.
		wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid;
		rd_take = s_axi_arvalid & ~rvalid;
		s_axi_awready = wr_take;
		s_axi_wready = wr_take;
		s_axi_arready = ~rvalid;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
		end
		events = '0;
		events[IRQ_WR_REFUSED] = wr_req & ~wr_ok;
		events[IRQ_RD_REFUSED] = rd_req & ~rd_ok;
		events[IRQ_FULL] = full & ~full_d;
		events[IRQ_EMPTY] = empty & ~empty_d;
		status_word = '0;
		status_word[3:0] = {near_empty, near_full, empty, full};
		status_word[8 +: PTR_W] = wr_count;
		status_word[16 +: PTR_W] = rd_count;
		next_ctrl = ctrl;
		next_thresh = thresh;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_bvalid = bvalid & ~s_axi_bready;
		next_bresp = bresp;
		if (wr_take) begin
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			unique case (s_axi_awaddr)
				OFF_CTRL: begin
					next_ctrl = (ctrl & ~wmask[CTRL_W-1:0]) | (s_axi_wdata[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
				end
				OFF_THRESH: begin
					if (s_axi_wstrb[0]) begin
						next_thresh.near_full = s_axi_wdata[NF_LSB +: PTR_W];
					end
					if (s_axi_wstrb[1]) begin
						next_thresh.near_empty = s_axi_wdata[NE_LSB +: PTR_W];
					end
				end
				OFF_STATUS: begin
				end
				OFF_IRQ_STAT: begin
					next_irq_stat = irq_stat & ~(s_axi_wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
				end
				OFF_IRQ_MASK: begin
					next_irq_mask = (irq_mask & ~wmask[IRQ_W-1:0]) | (s_axi_wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
				end
				default: begin
					next_bresp = RESP_SLVERR;
				end
			endcase
		end
		// A fresh event outranks a write-one-to-clear in the same cycle.
		next_irq_stat = next_irq_stat | events;
		rd_word = '0;
		next_rresp = RESP_OKAY;
		unique case (s_axi_araddr)
			OFF_CTRL: rd_word[CTRL_W-1:0] = ctrl;
			OFF_THRESH: begin
				rd_word[NF_LSB +: PTR_W] = thresh.near_full;
				rd_word[NE_LSB +: PTR_W] = thresh.near_empty;
			end
			OFF_STATUS: rd_word = status_word;
			OFF_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
			OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
			default: next_rresp = RESP_SLVERR;
		endcase
		next_rvalid = rvalid & ~s_axi_rready;
		next_rdata = rdata;
		if (rd_take) begin
			next_rvalid = 1'b1;
			next_rdata = rd_word;
		end else begin
			next_rresp = rresp;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
			thresh <= {NE_RST, NF_RST};
			irq_stat <= '0;
			irq_mask <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= '0;
			full_d <= 1'b0;
			empty_d <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			thresh <= next_thresh;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			full_d <= full;
			empty_d <= empty;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign irq = |(irq_stat & irq_mask);

endmodule // cfo_fifo

// File: src/cfo_pkg.sv
package cfo_pkg;

	// ==========================================================
	// Storage geometry
	localparam int DATA_W = 8;
	localparam int IDX_W = 4;
	localparam int PTR_W = 5;
	localparam logic [PTR_W-1:0] DEPTH = 5'h10;

	// ==========================================================
	// Pointer crossing
	localparam int SYNC_MAX = 4;
	localparam logic [2:0] SYNC_BIAS = 3'h2;
	localparam logic [2:0] CLR_STAGES = 3'h2;

	// ==========================================================
	// Register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Control register layout, bit 0 upward from clr_sync
	typedef struct packed {
		logic [2:0] sync_depth;
		logic dual_mode;
		logic full_cycle;
		logic unf_prot;
		logic ovf_prot;
		logic related_clk;
		logic out_reg;
		logic show_ahead;
		logic clr_sync;
	} cfo_ctrl_t;
	localparam int CTRL_W = 11;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h00_30;

	// Threshold layout: near-full in [4:0], near-empty in [12:8].
	typedef struct packed {
		logic [PTR_W-1:0] near_empty;
		logic [PTR_W-1:0] near_full;
	} cfo_thresh_t;
	localparam int NF_LSB = 0;
	localparam int NE_LSB = 8;
	localparam logic [PTR_W-1:0] NF_RST = 5'h0E;
	localparam logic [PTR_W-1:0] NE_RST = 5'h02;

	// Interrupt bits.
	localparam int IRQ_W = 4;
	localparam int IRQ_WR_REFUSED = 0;
	localparam int IRQ_RD_REFUSED = 1;
	localparam int IRQ_FULL = 2;
	localparam int IRQ_EMPTY = 3;

	function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

endpackage

// File: src/cfo_sync.sv
`timescale 1ns/1ps

module cfo_sync import cfo_pkg::*; #(
	parameter int W = 1
) (
	// Clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	// Chain length, 1 to SYNC_MAX
	input wire logic [2:0] depth,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ==========================================================
	// Shift chain
	logic [SYNC_MAX-1:0][W-1:0] chain;
	logic [SYNC_MAX-1:0][W-1:0] next_chain;
	logic [2:0] tap;

	always_comb begin
		next_chain = {chain[SYNC_MAX-2:0], d};
		tap = (depth == 3'h0) ? 3'h0 : depth - 3'h1;
		q = chain[tap[1:0]];
	end

	always_ff @(posedge aclk or posedge clr) begin
		if (clr) begin
			chain <= '0;
		end else if (!aresetn) begin
			chain <= '0;
		end else begin
			chain <= next_chain;
		end
	end

endmodule // cfo_sync

// File: verif/cfo_fifo_monitor.sv
`timescale 1ns/1ps

module cfo_fifo_monitor import cfo_pkg::*; (
	// Clock, reset and clear
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aclr,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Buffer sides
	input wire logic wr_req,
	input wire logic rd_req,
	input wire logic full,
	input wire logic empty,
	input wire logic near_empty,
	input wire logic [PTR_W-1:0] wr_count,
	input wire logic [PTR_W-1:0] rd_count
);
	// ==========================================================
	// Properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_aw_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid;
	endsequence
	sequence s_wr_take;
		!aclr && wr_req && !rd_req && !full;
	endsequence

	wr_resp_a: assert property (s_aw_take |=> s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	// The write-side count sees its own pointer at once; only the far pointer is delayed.
	wr_count_a: assert property (s_wr_take ##1 !aclr |-> wr_count == $past(wr_count) + 5'h01)
		else $error("write count did not advance");
	full_depth_a: assert property (full |-> wr_count == DEPTH)
		else $error("full flag without full count");
	full_hold_a: assert property (full && wr_req && !rd_req && !aclr |=> full && wr_count == DEPTH)
		else $error("write taken while full");
	empty_hold_a: assert property (empty && rd_req && !wr_req && !aclr |=> empty)
		else $error("read taken while empty");
	// With the clear resynchronised, the read pointer lags three edges, and the write count
	// is taken against it, so the count is only known to be clear once both sides are.
	clr_wr_a: assert property (aclr [*4] |-> wr_count == '0 && !full)
		else $error("clear missed write side");
	clr_rd_a: assert property (aclr [*4] |-> empty && near_empty && rd_count == '0)
		else $error("clear missed read side");
endmodule // cfo_fifo_monitor

bind cfo_fifo cfo_fifo_monitor mon (.aclk, .aresetn, .aclr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .wr_req, .rd_req, .full, .empty, .near_empty, .wr_count, .rd_count);

// File: verif/cfo_user.sv
`timescale 1ns/1ps

module cfo_user import cfo_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Commands from the bench
	input wire logic wr_go,
	input wire logic rd_go,
	// Buffer side
	output logic wr_req,
	output logic [DATA_W-1:0] wr_data,
	output logic rd_req
);
	// ==========================================================
	// Strobes and a counting data source
	logic [DATA_W-1:0] seq;
	logic [DATA_W-1:0] next_seq;

	assign wr_req = wr_go;
	assign rd_req = rd_go;
	// Idle data is inverted so a stale word can never pass for a fresh one.
	assign wr_data = wr_go ? seq : ~seq;

	always_comb begin
		next_seq = wr_go ? seq + 8'h01 : seq;
	end
	always_ff @(posedge aclk) begin
		seq <= aresetn ? next_seq : '0;
	end
endmodule // cfo_user

// File: verif/tb.sv
`timescale 1ns/1ps

module tb import cfo_pkg::*; ;
	logic aclk, aresetn, aclr, wr_go, rd_go, wr_req, rd_req, full, near_full, empty, near_empty, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
	logic [DATA_W-1:0] wr_data, rd_data, pseq;
	logic [PTR_W-1:0] wr_count, rd_count;
	int err_count, total_checks;
	// both sides share aclk, so the related setting is legal here.
	logic [31:0] cv [6] = '{32'h0000_0030, 32'h0000_0034, 32'h0000_0032, 32'h0000_04b0,
		32'h0000_04bc, 32'h0000_03b0};
	int wv [6] = '{1, 1, 1, 3, 2, 2};
	int rv [6] = '{1, 2, 0, 2, 2, 2};

	cfo_fifo dut (.aclk, .aresetn, .aclr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_req, .wr_data, .full, .near_full,
		.wr_count, .rd_req, .rd_data, .empty, .near_empty, .rd_count, .irq);
	cfo_user user (.aclk, .aresetn, .wr_go, .rd_go, .wr_req, .wr_data, .rd_req);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// ==========================================================
	// Access tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Offers the strobes at one rising edge and drops them just after it. Called between
	// edges with aclk low, it first waits for a rising edge, so the strobes only change right after one.
	task automatic step(input logic w, input logic r);
		if (!aclk) @(posedge aclk);
		wr_go <= w;
		rd_go <= r;
		@(posedge aclk);
		wr_go <= 1'b0;
		rd_go <= 1'b0;
		if (w) pseq++;
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw_done) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !w_done) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		@(posedge aclk iff s_axi_bvalid);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk iff s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk iff s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axr(a, d, r);
		chk(d, exp);
	endtask

	// Writes one word, counts cycles until the read side shows it, then reads it back.
	task automatic lat(input logic [31:0] c, input int nw, input int nr);
		logic [DATA_W-1:0] wd;
		int n;
		axw(OFF_CTRL, c);
		wd = pseq;
		step(1'b1, 1'b0);
		@(negedge aclk);
		n = 1;
		while ((c[1] ? rd_data !== wd : empty === 1'b1) && n < 9) begin
			@(negedge aclk);
			n++;
		end
		chk(n, nw);
		step(1'b0, 1'b1);
		@(negedge aclk);
		n = 1;
		while (rd_data !== wd && n < 9) begin
			@(negedge aclk);
			n++;
		end
		if (!c[1]) chk(n, nr);
		@(negedge aclk);
		chk(empty, 1'b1);
	endtask

	// ==========================================================
	// Sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		{aresetn, aclr, wr_go, rd_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, pseq} = '0;
		s_axi_wstrb = 4'hf;
		err_count = 0;
		total_checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(OFF_CTRL, 32'(CTRL_RST));
		rchk(OFF_THRESH, 32'h0000_020e);
		rchk(OFF_STATUS, 32'h0000_000a);
		axr(8'h14, d, r);
		chk(r, RESP_SLVERR);
		chk(d, 32'h0000_0000);
		axw(8'h14, 32'h0000_00ff);
		chk(bresp_seen, RESP_SLVERR);
		axw(OFF_IRQ_MASK, 32'h0000_000f);
		chk(bresp_seen, RESP_OKAY);
		for (int i = 1; i <= 16; i++) begin
			step(1'b1, 1'b0);
			@(negedge aclk);
			chk(wr_count, i);
			chk(near_full, i >= NF_RST);
			chk(near_empty, i < NE_RST);
		end
		step(1'b1, 1'b0);
		@(negedge aclk);
		chk(wr_count, DEPTH);
		chk(irq, 1'b1);
		rchk(OFF_IRQ_STAT, 32'h0000_0005);
		axw(OFF_IRQ_STAT, 32'h0000_0005);
		@(negedge aclk);
		chk(irq, 1'b0);
		axw(OFF_CTRL, 32'h0000_0070);
		step(1'b1, 1'b1);
		@(negedge aclk);
		chk(full, 1'b1);
		chk(rd_data, 8'h00);
		for (int i = 1; i <= 16; i++) begin
			step(1'b0, 1'b1);
			@(negedge aclk);
			chk(rd_data, (i < 16) ? i : 17);
		end
		step(1'b0, 1'b1);
		@(negedge aclk);
		chk(rd_count, 5'h00);
		rchk(OFF_IRQ_STAT, 32'h0000_000a);
		axw(OFF_IRQ_STAT, 32'h0000_000a);
		for (int i = 0; i < 6; i++) lat(cv[i], wv[i], rv[i]);
		axw(OFF_CTRL, 32'h0000_0031);
		step(1'b1, 1'b0);
		@(negedge aclk);
		step(1'b1, 1'b0);
		@(posedge aclk);
		aclr <= 1'b1;
		repeat (4) @(posedge aclk);
		aclr <= 1'b0;
		@(negedge aclk);
		chk({empty, near_empty, wr_count, rd_count}, 32'h0000_0c00);
		rchk(OFF_CTRL, 32'h0000_0031);
		summarize();
	end

	initial begin
		repeat (4000) @(posedge aclk);
		err_count++;
		summarize();
	end
endmodule // tb
